/* design/aam_pkg.sv */
// Shared constants and carrier types for the alert monitor block
package aam_pkg;

	// ----------------------------------------
	// Register pointers
	// ----------------------------------------
	localparam logic [7:0] PTR_STATUS = 8'h01;
	localparam logic [7:0] PTR_CONFIG = 8'h02;
	localparam logic [7:0] PTR_LOW = 8'h03;
	localparam logic [7:0] PTR_HIGH = 8'h04;
	localparam logic [7:0] PTR_HYST = 8'h05;
	localparam logic [7:0] PTR_MIN = 8'h06;

	// ----------------------------------------
	// Field layout and reset values
	// ----------------------------------------
	localparam int VALUE_W = 12;
	localparam int WORD_W = 16;
	localparam int FLAG_OVER_BIT = 1;
	localparam int FLAG_UNDER_BIT = 0;
	localparam int CFG_BYTE_W = 8;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [11:0] LOW_RESET = 12'h000;
	localparam logic [11:0] HIGH_RESET = 12'hFFF;
	localparam logic [11:0] HYST_RESET = 12'h000;
	localparam logic [11:0] MIN_RESET = 12'hFFF;
	localparam logic [2:0] INTERVAL_OFF = 3'h0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CORE_CLK_PERIOD_NS = 40;
	localparam int SINGLE_CONV_NS_DEFAULT = 1000;
	// Code 1 means x32 = 2^5, so shift by code + 4
	localparam int INTERVAL_SHIFT_OFFSET = 4;
	localparam int TIMER_W = 24;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic write;
		logic [7:0] pointer;
		logic [15:0] wdata;
	} aam_req_t;

	typedef struct packed {
		logic [2:0] interval;
		logic hold;
		logic flag_en;
		logic pin_en;
		logic rsvd;
		logic polarity;
	} aam_cfg_t;

	typedef enum logic [2:0] {
		SEQ_OFF = 3'b001,
		SEQ_CONV = 3'b010,
		SEQ_WAIT = 3'b100
	} aam_seq_t;

endpackage : aam_pkg

/* design/aam_sync.sv */
// Three-stage level synchroniser with agreement filter
`timescale 1ns/1ps

module aam_sync (
	input wire logic clk,
	input wire logic nrst,
	input wire logic d,
	output logic q
);
	import aam_pkg::*;

	logic s1;
	logic s2;
	logic s3;
	logic next_q;

	// ----------------------------------------
	// Accept a change once stages two and three agree
	// ----------------------------------------
	always_comb begin
		next_q = (s2 == s3) ? s3 : q;
	end

	// Stage registers; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			q <= 1'b0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q <= next_q;
		end
	end

endmodule : aam_sync

/* design/aam_link_port.sv */
// Link-clock side of the register port with toggle handshake
`timescale 1ns/1ps

module aam_link_port (
	input wire logic link_clk,
	input wire logic link_nrst,
	input wire logic req_valid,
	input wire aam_pkg::aam_req_t req,
	output logic req_busy,
	output logic rsp_valid,
	output logic [15:0] rsp_rdata,
	output aam_pkg::aam_req_t held_req,
	output logic req_tgl,
	input wire logic ack_tgl,
	input wire logic [15:0] core_rdata
);
	import aam_pkg::*;

	logic ack_lvl;
	logic ack_seen;
	logic next_busy;
	logic next_valid;
	logic [WORD_W-1:0] next_rdata;
	aam_req_t next_held;
	logic next_tgl;
	logic next_seen;

	aam_sync u_ack_sync (
		.clk(link_clk),
		.nrst(link_nrst),
		.d(ack_tgl),
		.q(ack_lvl)
	);

	// ----------------------------------------
	// Capture a request, wait for the core to answer
	// ----------------------------------------
	always_comb begin
		next_busy = req_busy;
		next_valid = 1'b0;
		next_rdata = rsp_rdata;
		next_held = held_req;
		next_tgl = req_tgl;
		next_seen = ack_seen;
		if (!req_busy && req_valid) begin
			next_held = req;
			next_tgl = ~req_tgl;
			next_busy = 1'b1;
		end else if (req_busy && (ack_lvl != ack_seen)) begin
			// Core word is held stable until the next request
			next_seen = ack_lvl;
			next_busy = 1'b0;
			next_valid = 1'b1;
			next_rdata = core_rdata;
		end
	end

	// Link-side state
	always_ff @(posedge link_clk) begin
		if (!link_nrst) begin
			req_busy <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			held_req <= '0;
			req_tgl <= 1'b0;
			ack_seen <= 1'b0;
		end else begin
			req_busy <= next_busy;
			rsp_valid <= next_valid;
			rsp_rdata <= next_rdata;
			held_req <= next_held;
			req_tgl <= next_tgl;
			ack_seen <= next_seen;
		end
	end

endmodule : aam_link_port

/* design/aam_top.sv */
// Automatic conversion and window alert control of a 12-bit converter
// Function
// - Three-bit interval field in config bits 7:5; zero disables automatic mode
// - Non-zero code starts automatic mode; period is conversion time x 32..2048
// - Interval field resets to zero, automatic mode off at power-up
// - Hold clear: alert self-clears once value is back inside by more than hysteresis
// - Hold set: alerts clear only by writing one to a flag
// - Flag enable bit gates the summary bit 15 of the result word
// - Pin enable zero releases the alert pin; one drives it
// - Polarity zero makes alert active low, one active high
// - Config bit 1 reads zero; controller writes zero
// - Lower limit at pointer 03h, reset zero; below raises under-range
// - Upper limit at pointer 04h, reset full scale; above raises over-range
// - Hysteresis at pointer 05h sets how far back inside before clearing
// - Automatic mode keeps smallest result in lowest register at 06h
// - Lowest register resets to full scale; writing full scale restarts tracking
// - Lowest register updates only while automatic mode is on
// - Value registers use bits 11:0; bits 15:12 read zero
// - Status 01h: over bit 1, under bit 0, write one clears
// - Summary bit high when enabled and either flag set, else zero
`timescale 1ns/1ps

module aam_top #(
	parameter int SINGLE_CONVERSION_PERIOD_NS = aam_pkg::SINGLE_CONV_NS_DEFAULT
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic link_nrst,
	input wire logic req_valid,
	input wire aam_pkg::aam_req_t req,
	output logic req_busy,
	output logic rsp_valid,
	output logic [15:0] rsp_rdata,
	input wire logic conv_done,
	input wire logic [11:0] conv_result,
	output logic conv_start,
	output logic auto_mode,
	output logic result_alert_bit,
	output logic alert_out,
	output logic alert_oe
);
	import aam_pkg::*;

	// ----------------------------------------
	// Timing constants
	// ----------------------------------------
	localparam int CONV_CYCLES_RAW =
		(SINGLE_CONVERSION_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) /
		CORE_CLK_PERIOD_NS;
	localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
	localparam logic [TIMER_W-1:0] TIMER_ONE = TIMER_W'(1);
	localparam logic [TIMER_W-1:0] TIMER_ZERO = TIMER_W'(0);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	aam_req_t held_req;
	logic req_tgl;
	logic req_lvl;
	logic req_seen;
	logic req_evt;
	logic ack_tgl;
	logic [WORD_W-1:0] core_rdata;

	aam_cfg_t cfg;
	logic [VALUE_W-1:0] low_limit;
	logic [VALUE_W-1:0] high_limit;
	logic [VALUE_W-1:0] hyst;
	logic [VALUE_W-1:0] lowest;
	logic flag_over;
	logic flag_under;

	aam_cfg_t next_cfg;
	logic [VALUE_W-1:0] next_low_limit;
	logic [VALUE_W-1:0] next_high_limit;
	logic [VALUE_W-1:0] next_hyst;
	logic [VALUE_W-1:0] next_lowest;
	logic next_flag_over;
	logic next_flag_under;
	logic next_req_seen;
	logic next_ack_tgl;
	logic [WORD_W-1:0] next_core_rdata;

	aam_seq_t seq;
	aam_seq_t next_seq;
	logic [TIMER_W-1:0] timer;
	logic [TIMER_W-1:0] next_timer;
	logic next_conv_start;
	logic auto_on;

	logic next_result_alert_bit;
	logic next_alert_out;
	logic next_alert_oe;

	logic wr_evt;
	logic over_hit;
	logic under_hit;
	logic over_back;
	logic under_back;
	logic [VALUE_W:0] high_minus_room;
	logic [VALUE_W:0] low_plus_room;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Cycles between automatic starts for an interval code
	function automatic logic [TIMER_W-1:0] interval_cycles(
		input logic [2:0] code
	);
		interval_cycles = TIMER_W'(CONV_CYCLES) <<
			(code + INTERVAL_SHIFT_OFFSET);
	endfunction : interval_cycles

	// Widen a value register to the bus word
	function automatic logic [WORD_W-1:0] value_word(
		input logic [VALUE_W-1:0] v
	);
		value_word = '0;
		value_word[VALUE_W-1:0] = v;
	endfunction : value_word

	// ----------------------------------------
	// Link side and request crossing
	// ----------------------------------------
	aam_link_port u_link (
		.link_clk(link_clk),
		.link_nrst(link_nrst),
		.req_valid(req_valid),
		.req(req),
		.req_busy(req_busy),
		.rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata),
		.held_req(held_req),
		.req_tgl(req_tgl),
		.ack_tgl(ack_tgl),
		.core_rdata(core_rdata)
	);

	aam_sync u_req_sync (
		.clk(core_clk),
		.nrst(nrst),
		.d(req_tgl),
		.q(req_lvl)
	);

	// Request event and write strobe in the core domain
	assign req_evt = (req_lvl != req_seen);
	assign wr_evt = req_evt && held_req.write;

	// ----------------------------------------
	// Limit comparisons on each conversion
	// ----------------------------------------
	assign over_hit = conv_done && (conv_result > high_limit);
	assign under_hit = conv_done && (conv_result < low_limit);
	assign high_minus_room = {1'b0, high_limit} - {1'b0, hyst};
	assign low_plus_room = {1'b0, low_limit} + {1'b0, hyst};
	// Back inside the limit by more than the hysteresis
	assign over_back = conv_done && !high_minus_room[VALUE_W] &&
		({1'b0, conv_result} < high_minus_room);
	assign under_back = conv_done &&
		({1'b0, conv_result} > low_plus_room);
	assign auto_on = (cfg.interval != INTERVAL_OFF);

	// ----------------------------------------
	// Register file, flags and read path
	// ----------------------------------------
	always_comb begin
		next_cfg = cfg;
		next_low_limit = low_limit;
		next_high_limit = high_limit;
		next_hyst = hyst;
		next_lowest = lowest;
		next_flag_over = flag_over;
		next_flag_under = flag_under;
		next_req_seen = req_seen;
		next_ack_tgl = ack_tgl;
		next_core_rdata = core_rdata;

		// Minimum tracking only in automatic mode
		if (auto_on && conv_done && (conv_result < lowest)) begin
			next_lowest = conv_result;
		end

		// Self-clear only when hold is off
		if (!cfg.hold && over_back) begin
			next_flag_over = 1'b0;
		end
		if (!cfg.hold && under_back) begin
			next_flag_under = 1'b0;
		end

		if (req_evt) begin
			next_req_seen = req_lvl;
			next_ack_tgl = ~ack_tgl;
			next_core_rdata = '0;
			if (wr_evt) begin
				unique case (held_req.pointer)
					PTR_STATUS: begin
						// Write one clears a flag
						if (held_req.wdata[FLAG_OVER_BIT]) begin
							next_flag_over = 1'b0;
						end
						if (held_req.wdata[FLAG_UNDER_BIT]) begin
							next_flag_under = 1'b0;
						end
					end
					PTR_CONFIG: begin
						next_cfg = held_req.wdata[CFG_BYTE_W-1:0];
						next_cfg.rsvd = 1'b0;
					end
					PTR_LOW: next_low_limit = held_req.wdata[VALUE_W-1:0];
					PTR_HIGH: next_high_limit = held_req.wdata[VALUE_W-1:0];
					PTR_HYST: next_hyst = held_req.wdata[VALUE_W-1:0];
					// Software write restarts tracking, wins over update
					PTR_MIN: next_lowest = held_req.wdata[VALUE_W-1:0];
					default: next_core_rdata = '0;
				endcase
			end else begin
				unique case (held_req.pointer)
					PTR_STATUS: begin
						next_core_rdata[FLAG_OVER_BIT] = flag_over;
						next_core_rdata[FLAG_UNDER_BIT] = flag_under;
					end
					PTR_CONFIG: begin
						next_core_rdata[CFG_BYTE_W-1:0] = cfg;
						next_core_rdata[1] = 1'b0;
					end
					PTR_LOW: next_core_rdata = value_word(low_limit);
					PTR_HIGH: next_core_rdata = value_word(high_limit);
					PTR_HYST: next_core_rdata = value_word(hyst);
					PTR_MIN: next_core_rdata = value_word(lowest);
					default: next_core_rdata = '0;
				endcase
			end
		end

		// A new violation wins over any clear in the same cycle
		if (over_hit) begin
			next_flag_over = 1'b1;
		end
		if (under_hit) begin
			next_flag_under = 1'b1;
		end
	end

	// Register state with documented reset values
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cfg <= CFG_RESET;
			low_limit <= LOW_RESET;
			high_limit <= HIGH_RESET;
			hyst <= HYST_RESET;
			lowest <= MIN_RESET;
			flag_over <= 1'b0;
			flag_under <= 1'b0;
			req_seen <= 1'b0;
			ack_tgl <= 1'b0;
			core_rdata <= '0;
		end else begin
			cfg <= next_cfg;
			low_limit <= next_low_limit;
			high_limit <= next_high_limit;
			hyst <= next_hyst;
			lowest <= next_lowest;
			flag_over <= next_flag_over;
			flag_under <= next_flag_under;
			req_seen <= next_req_seen;
			ack_tgl <= next_ack_tgl;
			core_rdata <= next_core_rdata;
		end
	end

	// ----------------------------------------
	// Automatic conversion sequencer
	// ----------------------------------------
	always_comb begin
		next_seq = seq;
		next_timer = timer;
		next_conv_start = 1'b0;
		if (timer != TIMER_ZERO) begin
			next_timer = timer - TIMER_ONE;
		end
		unique case (seq)
			SEQ_OFF: begin
				if (auto_on) begin
					next_seq = SEQ_CONV;
					next_conv_start = 1'b1;
					next_timer = interval_cycles(cfg.interval) - TIMER_ONE;
				end
			end
			SEQ_CONV: begin
				if (conv_done) begin
					next_seq = SEQ_WAIT;
				end
			end
			SEQ_WAIT: begin
				if (timer == TIMER_ZERO) begin
					next_seq = SEQ_CONV;
					next_conv_start = 1'b1;
					next_timer = interval_cycles(cfg.interval) - TIMER_ONE;
				end
			end
		endcase
		// Zero code stops automatic mode at once
		if (!auto_on) begin
			next_seq = SEQ_OFF;
			next_conv_start = 1'b0;
			next_timer = TIMER_ZERO;
		end
	end

	// Sequencer state
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			seq <= SEQ_OFF;
			timer <= TIMER_ZERO;
			conv_start <= 1'b0;
		end else begin
			seq <= next_seq;
			timer <= next_timer;
			conv_start <= next_conv_start;
		end
	end

	// ----------------------------------------
	// Alert pin and summary bit
	// ----------------------------------------
	always_comb begin
		next_result_alert_bit = cfg.flag_en &&
			(next_flag_over || next_flag_under);
		// Active level picked by polarity
		next_alert_out = (next_flag_over || next_flag_under) ~^
			cfg.polarity;
		next_alert_oe = cfg.pin_en;
	end

	// Output registers
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			auto_mode <= 1'b0;
			result_alert_bit <= 1'b0;
			alert_out <= 1'b1;
			alert_oe <= 1'b0;
		end else begin
			auto_mode <= auto_on;
			result_alert_bit <= next_result_alert_bit;
			alert_out <= next_alert_out;
			alert_oe <= next_alert_oe;
		end
	end

endmodule : aam_top

/* test/aam_top_sva.sv */
// Port-level assertion checker for the alert monitor top
`timescale 1ns/1ps

module aam_top_sva #(
	parameter int SINGLE_CONVERSION_PERIOD_NS = 1000
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic link_nrst,
	input wire logic req_valid,
	input wire logic req_busy,
	input wire logic rsp_valid,
	input wire logic conv_start,
	input wire logic auto_mode
);
	localparam int CONV_CYC = (SINGLE_CONVERSION_PERIOD_NS + 39) / 40;
	localparam int MIN_GAP = 32 * CONV_CYC - 1;
	logic [23:0] gap;
	logic [23:0] next_gap;

	// ----------------------------------------
	// Start spacing counter
	// ----------------------------------------
	// Saturates while idle so the first start is never judged
	always_comb begin
		if (!auto_mode || gap == 24'hFFFFFF) begin
			next_gap = 24'hFFFFFF;
		end else begin
			next_gap = gap + 24'h000001;
		end
		if (conv_start) begin
			next_gap = 24'h000000;
		end
	end
	always_ff @(posedge core_clk) begin
		gap <= !nrst ? 24'hFFFFFF : next_gap;
	end

	// ----------------------------------------
	// Named steps of a register transfer
	// ----------------------------------------
	sequence s_take;
		req_valid && !req_busy;
	endsequence
	sequence s_answer;
		##[3:16] rsp_valid;
	endsequence

	a_start_pulse: assert property (@(posedge core_clk)
		disable iff (!nrst) conv_start |=> !conv_start)
		else $error("start pulse too long");
	a_start_gap: assert property (@(posedge core_clk)
		disable iff (!nrst) conv_start |-> gap >= MIN_GAP)
		else $error("starts closer than shortest interval");
	a_auto_start: assert property (@(posedge core_clk)
		disable iff (!nrst)
		$rose(auto_mode) |-> $past(conv_start) or ##[0:2] conv_start)
		else $error("no start on entering automatic mode");
	a_off_quiet: assert property (@(posedge core_clk)
		disable iff (!nrst) $fell(auto_mode) |=> !conv_start [*8])
		else $error("start while automatic mode off");
	a_reset_off: assert property (@(posedge core_clk)
		disable iff (!nrst) $rose(nrst) |-> !auto_mode && !conv_start)
		else $error("automatic mode on after reset");
	a_take_busy: assert property (@(posedge link_clk)
		disable iff (!link_nrst) s_take |=> req_busy)
		else $error("request taken without busy");
	a_answer_bound: assert property (@(posedge link_clk)
		disable iff (!link_nrst) $rose(req_busy) |-> s_answer)
		else $error("answer late");
	a_rsp_after_busy: assert property (@(posedge link_clk)
		disable iff (!link_nrst) rsp_valid |-> $past(req_busy) && !req_busy)
		else $error("answer without pending request");
	a_rsp_pulse: assert property (@(posedge link_clk)
		disable iff (!link_nrst) rsp_valid |=> !rsp_valid)
		else $error("answer pulse too long");
endmodule : aam_top_sva

bind aam_top aam_top_sva #(
	.SINGLE_CONVERSION_PERIOD_NS(SINGLE_CONVERSION_PERIOD_NS)
) u_sva (
	.core_clk(core_clk),
	.nrst(nrst),
	.link_clk(link_clk),
	.link_nrst(link_nrst),
	.req_valid(req_valid),
	.req_busy(req_busy),
	.rsp_valid(rsp_valid),
	.conv_start(conv_start),
	.auto_mode(auto_mode)
);

/* test/aam_ctrl_model.sv */
// Register port controller model on the link side
`timescale 1ns/1ps

module aam_ctrl_model (
	input wire logic link_clk,
	output logic req_valid,
	output aam_pkg::aam_req_t req,
	input wire logic req_busy,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_rdata
);
	import aam_pkg::*;

	initial begin
		req_valid = 1'b0;
		req = '0;
	end

	// One whole transfer: hold until taken, then wait for the answer
	task automatic xfer(input logic w, input logic [7:0] p,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		@(posedge link_clk);
		#1 req_valid = 1'b1;
		req = '{write: w, pointer: p, wdata: d};
		while (req_busy === 1'b1 && n < 40) begin
			@(posedge link_clk);
			#1 n++;
		end
		@(posedge link_clk);
		#1 req_valid = 1'b0;
		req.wdata = ~d;
		do begin
			@(posedge link_clk);
			#1 n++;
		end while (rsp_valid !== 1'b1 && n < 80);
		// No answer in time leaves an unknown word for the caller to flag
		q = (rsp_valid === 1'b1) ? rsp_rdata : 'x;
	endtask : xfer
endmodule : aam_ctrl_model

/* test/aam_top_tb.sv */
// Self-checking bench for the alert monitor block
`timescale 1ns/1ps

module aam_top_tb;
	import aam_pkg::*;
	logic core_clk, nrst, link_clk, link_nrst, req_valid, req_busy;
	logic rsp_valid, conv_done, conv_start, auto_mode;
	logic result_alert_bit, alert_out, alert_oe;
	logic [15:0] rsp_rdata, rd;
	logic [11:0] conv_result, auto_val;
	aam_req_t req;
	int fails, n_checks, n;

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end

	aam_top #(.SINGLE_CONVERSION_PERIOD_NS(40)) dut (.core_clk(core_clk),
		.nrst(nrst), .link_clk(link_clk), .link_nrst(link_nrst),
		.req_valid(req_valid), .req(req), .req_busy(req_busy),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.conv_done(conv_done), .conv_result(conv_result),
		.conv_start(conv_start), .auto_mode(auto_mode),
		.result_alert_bit(result_alert_bit), .alert_out(alert_out),
		.alert_oe(alert_oe));
	aam_ctrl_model u_ctrl (.link_clk(link_clk), .req_valid(req_valid),
		.req(req), .req_busy(req_busy), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata));

	// Converter answers each start three cycles later
	always @(posedge core_clk) begin
		#1;
		if (conv_start === 1'b1) begin
			repeat (2) @(posedge core_clk);
			#1 conv_done = 1'b1;
			conv_result = auto_val;
			@(posedge core_clk);
			#1 conv_done = 1'b0;
		end
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] p, input logic [15:0] d);
		u_ctrl.xfer(1'b1, p, d, rd);
		check("write answer", rd, 16'h0000);
	endtask : wr
	task automatic rdchk(input logic [7:0] p, input logic [15:0] e);
		u_ctrl.xfer(1'b0, p, 16'h0000, rd);
		check("register", rd, e);
	endtask : rdchk
	task automatic conv(input logic [11:0] v);
		@(posedge core_clk);
		#1 conv_done = 1'b1;
		conv_result = v;
		@(posedge core_clk);
		#1 conv_done = 1'b0;
	endtask : conv
	task automatic pins(input logic [2:0] e);
		repeat (2) @(posedge core_clk);
		#1 check("pins", {13'h0, result_alert_bit, alert_out, alert_oe},
			{13'h0, e});
	endtask : pins
	task automatic next_start(output int k);
		k = 0;
		do begin
			@(posedge core_clk);
			#1 k++;
		end while (conv_start !== 1'b1 && k < 5000);
	endtask : next_start
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	// Hang guard
	initial begin
		#2000000;
		fails++;
		give_verdict();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		fails = 0;
		n_checks = 0;
		nrst = 1'b0;
		link_nrst = 1'b0;
		conv_done = 1'b0;
		conv_result = 12'h000;
		auto_val = 12'h300;
		repeat (8) @(posedge core_clk);
		#1 nrst = 1'b1;
		@(posedge link_clk);
		#1 link_nrst = 1'b1;
		repeat (6) @(posedge core_clk);
		rdchk(PTR_LOW, 16'h0000);
		rdchk(PTR_HIGH, 16'h0FFF);
		rdchk(PTR_HYST, 16'h0000);
		rdchk(PTR_MIN, 16'h0FFF);
		rdchk(PTR_CONFIG, 16'h0000);
		rdchk(PTR_STATUS, 16'h0000);
		pins(3'b010);
		wr(8'h07, 16'h0ABC);
		rdchk(8'h07, 16'h0000);
		// Upper nibble always written as zero
		wr(PTR_LOW, 16'h0100);
		rdchk(PTR_LOW, 16'h0100);
		wr(PTR_HIGH, 16'h0800);
		wr(PTR_HYST, 16'h0010);
		// Summary, pin, high polarity; reserved bit written as zero
		wr(PTR_CONFIG, 16'h000D);
		rdchk(PTR_CONFIG, 16'h000D);
		conv(12'h050);
		rdchk(PTR_STATUS, 16'h0001);
		pins(3'b111);
		rdchk(PTR_MIN, 16'h0FFF);
		conv(12'h110);
		rdchk(PTR_STATUS, 16'h0001);
		conv(12'h111);
		rdchk(PTR_STATUS, 16'h0000);
		pins(3'b001);
		conv(12'h801);
		rdchk(PTR_STATUS, 16'h0002);
		conv(12'h7F0);
		rdchk(PTR_STATUS, 16'h0002);
		conv(12'h7EF);
		rdchk(PTR_STATUS, 16'h0000);
		// Hold on, summary off, low-active pin
		wr(PTR_CONFIG, 16'h0014);
		conv(12'h900);
		pins(3'b001);
		conv(12'h100);
		rdchk(PTR_STATUS, 16'h0002);
		wr(PTR_STATUS, 16'h0002);
		rdchk(PTR_STATUS, 16'h0000);
		pins(3'b011);
		wr(PTR_CONFIG, 16'h0010);
		pins(3'b010);
		// Each interval code, with minimum tracking running
		for (int c = 1; c < 8; c++) begin
			auto_val = (c == 1) ? 12'h300 : (c == 2) ? 12'h200 : 12'h250;
			wr(PTR_CONFIG, {8'h00, 3'(c), 5'h00});
			next_start(n);
			next_start(n);
			check("period", 16'(n), 16'(32 << (c - 1)));
			wr(PTR_CONFIG, 16'h0000);
		end
		repeat (3) @(posedge core_clk);
		#1 check("auto", {15'h0, auto_mode}, 16'h0000);
		rdchk(PTR_MIN, 16'h0200);
		wr(PTR_MIN, 16'h0FFF);
		rdchk(PTR_MIN, 16'h0FFF);
		give_verdict();
	end
endmodule : aam_top_tb
